/* dv/port_c_pin_mux_analog_select_tb.sv */
// Self-checking bench for the port C upper-pin mux and analog-select block.
// Assumes the package and constants header are compiled ahead of it.
`timescale 1ns/1ps

module port_c_pin_mux_analog_select_tb;
    import pcm_pkg::*;

    // ----------------------------------------
    // Row type and signals
    // ----------------------------------------
    // ctl bits: ccp_en ccp pwm_en pwm shutdown spi_act sdo tosc_en
    typedef struct packed
    {
        logic [7:0] dir;
        logic [7:0] lat;
        logic [7:0] ctl;
        logic [2:0] oe;
        logic [2:0] out;
    } pcm_tb_row_t;

    // Pin order in oe/out: [2] pin 7, [1] pin 6, [0] pin 5
    pcm_tb_row_t rows [12] = '{
        '{8'h00, 8'he0, 8'h00, 3'h7, 3'h7}, '{8'h00, 8'h00, 8'h00, 3'h7, 3'h0},
        '{8'hff, 8'he0, 8'h00, 3'h0, 3'h0}, '{8'ha0, 8'h40, 8'h00, 3'h2, 3'h2},
        '{8'h00, 8'h00, 8'hc0, 3'h7, 3'h1}, '{8'h00, 8'h20, 8'h80, 3'h7, 3'h0},
        '{8'h00, 8'h00, 8'hb0, 3'h7, 3'h1}, '{8'h00, 8'h20, 8'h28, 3'h6, 3'h0},
        '{8'h00, 8'h00, 8'h06, 3'h7, 3'h4}, '{8'h00, 8'h80, 8'h04, 3'h7, 3'h0},
        '{8'h00, 8'he0, 8'h01, 3'h1, 3'h1}, '{8'h00, 8'he0, 8'h07, 3'h1, 3'h1}
    };

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] pin_in = 3'h0;
    logic [7:0] ctl = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [2:0] pin_out, pin_oe;
    logic cap, t0, tsh, ss_n, tosc_act;
    logic [1:0] conv;
    logic [4:0] ans_lo;
    logic [3:0] ans_hi;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int checks_done = 0;

    always #50 mclk = ~mclk;

    pcm_top dut
    (
        .MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CCP_OUT_EN(ctl[7]),
        .CCP_OUT(ctl[6]), .PWM_A_EN(ctl[5]), .PWM_A(ctl[4]),
        .PWM_SHUTDOWN(ctl[3]), .SPI_ACTIVE(ctl[2]), .SPI_SDO(ctl[1]),
        .TOSC_EN(ctl[0]), .CAPTURE_IN(cap), .FIRST_TIMER_CNT(t0),
        .SHARED_TIMER_CNT(tsh), .SLAVE_SEL_N(ss_n),
        .TOSC_PINS_ACTIVE(tosc_act), .CONV_CH_READY(conv),
        .ANALOG_SEL_LOW(ans_lo), .ANALOG_SEL_HIGH(ans_hi)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_fail++;
            $display("ERROR apb_wait expected 1 seen %b", pready);
            final_report();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(what, {24'h0, exp}, rd);
    endtask : rdchk

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            wr(8'h08, rows[i].dir);
            wr(8'h04, rows[i].lat);
            ctl <= rows[i].ctl;
            repeat (3) @(posedge mclk);
            chk("oe", rows[i].oe, pin_oe);
            chk("out", rows[i].out, pin_out&pin_oe);
        end
        ctl <= 8'h00;
        // A second reset in mid-run must restore the drive-enable, direction and analog-select defaults
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("oe_in_reset", 0, pin_oe);
        chk("ans_lo_in_reset", 5'h1f, ans_lo);
        chk("ans_hi_in_reset", 4'hf, ans_hi);
        reset_n <= 1'b1;
        rdchk("dir_rst", 8'h08, 8'hff);
        rdchk("ans_lo_rst", 8'h0c, 8'hf8);
        rdchk("ans_hi_rst", 8'h10, 8'h0f);
        wr(8'h0c, 8'hff);
        rdchk("ans_lo_ones", 8'h0c, 8'hf8);
        wr(8'h0c, 8'h50);
        rdchk("ans_lo_mix", 8'h0c, 8'h50);
        chk("ans_lo_port", 5'h0a, ans_lo);
        wr(8'h10, 8'hf5);
        rdchk("ans_hi_mix", 8'h10, 8'h05);
        chk("ans_hi_port", 4'h5, ans_hi);
        // Pin 6 analog-selected, pins 5 and 7 digital
        pin_in <= 3'b111;
        repeat (5) @(posedge mclk);
        rdchk("levels_c6_ana", 8'h00, 8'ha0);
        chk("shared_cnt_ana", 0, tsh);
        wr(8'h10, 8'h00);
        rdchk("levels_dig", 8'h00, 8'he0);
        chk("slave_sel_hi", 1, ss_n);
        chk("shared_cnt_hi", 1, tsh);
        chk("capture_hi", 1, cap);
        chk("first_cnt_hi", 1, t0);
        chk("conv_ready_in", 2'b11, conv);
        pin_in <= 3'b000;
        repeat (5) @(posedge mclk);
        chk("slave_sel_lo", 0, ss_n);
        chk("capture_lo", 0, cap);
        pin_in <= 3'b111;
        ctl <= 8'h01;
        repeat (5) @(posedge mclk);
        rdchk("levels_tosc", 8'h00, 8'h20);
        chk("tosc_active", 1, tosc_act);
        ctl <= 8'h00;
        wr(8'h08, 8'h00);
        repeat (2) @(posedge mclk);
        chk("capture_out", 0, cap);
        chk("conv_ready_out", 2'b00, conv);
        // Writes to the levels word land in the output latch
        wr(8'h00, 8'ha5);
        rdchk("latch_via_levels", 8'h04, 8'ha5);
        chk("pin_out_latch", 3'h5, pin_out);
        // Unmapped word: refused, nothing written, zero read data
        apb(1'b1, 8'h14, 8'h55);
        chk("slverr_wr", 1, err);
        apb(1'b0, 8'h14, 8'h00);
        chk("slverr_rd", 1, err);
        chk("rdata_unmapped", 0, rd);
        final_report();
    end

endmodule : port_c_pin_mux_analog_select_tb

/* inc/pcm_consts.svh */
// Constants for the port C upper-pin mux and analog-select block.
// Assumes inclusion by bare name from the package and the top-level design file.
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets on APB
// ----------------------------------------
`define PCM_OFF_LEVELS 8'h00
`define PCM_OFF_LATCH 8'h04
`define PCM_OFF_DIR 8'h08
`define PCM_OFF_ANS_LO 8'h0c
`define PCM_OFF_ANS_HI 8'h10

// ----------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------
`define PCM_DIR_RST 8'hff
`define PCM_LAT_RST 8'h00
`define PCM_ANS_LO_RST 8'hf8
`define PCM_ANS_HI_RST 8'h0f
`define PCM_ANS_LO_MASK 8'hf8
`define PCM_ANS_HI_MASK 8'h0f
`define PCM_NO_BITS 8'h00

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define PCM_P5 5
`define PCM_P6 6
`define PCM_P7 7
`define PCM_L5 0
`define PCM_L6 1
`define PCM_L7 2
`define PCM_ANS_C6 0
`define PCM_ANS_C7 1
`define PCM_ANS_LO_TOP 7
`define PCM_ANS_LO_BOT 3
`define PCM_ANS_HI_TOP 3
`define PCM_NPINS 3

`endif

/* inc/pcm_pkg.sv */
// Types shared by the port C pin-mux block.
// Assumes the constants header sits on the include path.
`include "pcm_consts.svh"

package pcm_pkg;

    typedef enum logic [2:0]
    {
        PCM_SEL_LEVELS,
        PCM_SEL_LATCH,
        PCM_SEL_DIR,
        PCM_SEL_ANS_LO,
        PCM_SEL_ANS_HI,
        PCM_SEL_NONE
    } pcm_reg_sel_t;

    function automatic pcm_reg_sel_t pcm_decode(input logic [7:0] addr);
        pcm_reg_sel_t sel;
        sel = PCM_SEL_NONE;
        unique case (addr)
            `PCM_OFF_LEVELS: sel = PCM_SEL_LEVELS;
            `PCM_OFF_LATCH: sel = PCM_SEL_LATCH;
            `PCM_OFF_DIR: sel = PCM_SEL_DIR;
            `PCM_OFF_ANS_LO: sel = PCM_SEL_ANS_LO;
            `PCM_OFF_ANS_HI: sel = PCM_SEL_ANS_HI;
            default: sel = PCM_SEL_NONE;
        endcase
        return sel;
    endfunction : pcm_decode

endpackage : pcm_pkg

/* logic/pcm_pin_mux.sv */
// Output select and drive enable for one port pin.
// Assumes all controls come from logic on the same clock.
`timescale 1ns/1ps

module pcm_pin_mux
(
    input wire logic dir_in,
    input wire logic latch_bit,
    input wire logic per_en,
    input wire logic per_val,
    input wire logic per_tri,
    input wire logic osc_own,
    output logic drive_val,
    output logic drive_en
);

    // Peripheral data wins over the latch when enabled
    assign drive_val = per_en ? per_val : latch_bit;
    // Oscillator and shutdown tri-state override the direction bit
    assign drive_en = !dir_in && !osc_own && !per_tri;

endmodule : pcm_pin_mux

/* logic/pcm_sync.sv */
// Two-stage synchroniser for pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps

module pcm_sync
#(
    parameter int WIDTH = 3
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1)
        $error("pcm_sync: WIDTH must be at least one");

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pcm_sync

/* logic/pcm_top.sv */
// Port C upper pins (5..7): direction, latch, peripheral overrides,
// analog-select control, APB register access.
// Assumes APB master on MCLK; peripheral controls come from MCLK logic;
// pin levels arrive asynchronously.
`timescale 1ns/1ps
`include "pcm_consts.svh"

module pcm_top
    import pcm_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [2:0] PIN_IN,
    output logic [2:0] PIN_OUT,
    output logic [2:0] PIN_OE,
    input wire logic CCP_OUT_EN,
    input wire logic CCP_OUT,
    input wire logic PWM_A_EN,
    input wire logic PWM_A,
    input wire logic PWM_SHUTDOWN,
    input wire logic SPI_ACTIVE,
    input wire logic SPI_SDO,
    input wire logic TOSC_EN,
    output logic CAPTURE_IN,
    output logic FIRST_TIMER_CNT,
    output logic SHARED_TIMER_CNT,
    output logic SLAVE_SEL_N,
    output logic TOSC_PINS_ACTIVE,
    output logic [1:0] CONV_CH_READY,
    output logic [4:0] ANALOG_SEL_LOW,
    output logic [3:0] ANALOG_SEL_HIGH
);

    if (ADDR_W < 8)
        $error("pcm_top: ADDR_W must be at least 8");

    // ----------------------------------------
    // Storage and wires
    // ----------------------------------------
    logic [7:0] latch_reg, dir_reg, ans_lo_reg, ans_hi_reg, levels, rd_next;
    logic [2:0] pin_sync, dig_in, in_off, dir_bits, lat_bits, drv_val, drv_en;
    logic [2:0] per_en, per_val, per_tri, osc_own;
    logic pready_reg, acc, wr_hit;
    pcm_reg_sel_t sel;

    // ----------------------------------------
    // Pin input synchronisation
    // ----------------------------------------
    pcm_sync #(.WIDTH(`PCM_NPINS)) u_sync
    (
        .clk(MCLK),
        .rst_n(RESET_N),
        .async_in(PIN_IN),
        .sync_out(pin_sync)
    );

    // Buffer off when analog-selected or owned by the oscillator
    assign in_off[`PCM_L5] = 1'b0;
    assign in_off[`PCM_L6] = ans_hi_reg[`PCM_ANS_C6] | TOSC_EN;
    assign in_off[`PCM_L7] = ans_hi_reg[`PCM_ANS_C7] | TOSC_EN;
    assign dig_in = pin_sync & ~in_off;

    // ----------------------------------------
    // Per-pin output mux
    // ----------------------------------------
    assign dir_bits = dir_reg[`PCM_P7:`PCM_P5];
    assign lat_bits = latch_reg[`PCM_P7:`PCM_P5];

    // Channel A takes precedence over the compare output when both run
    assign per_en[`PCM_L5] = PWM_A_EN | CCP_OUT_EN;
    assign per_val[`PCM_L5] = PWM_A_EN ? PWM_A : CCP_OUT;
    assign per_tri[`PCM_L5] = PWM_A_EN & PWM_SHUTDOWN;
    assign osc_own[`PCM_L5] = 1'b0;
    assign per_en[`PCM_L6] = 1'b0;
    assign per_val[`PCM_L6] = 1'b0;
    assign per_tri[`PCM_L6] = 1'b0;
    assign osc_own[`PCM_L6] = TOSC_EN;
    assign per_en[`PCM_L7] = SPI_ACTIVE;
    assign per_val[`PCM_L7] = SPI_SDO;
    assign per_tri[`PCM_L7] = 1'b0;
    assign osc_own[`PCM_L7] = TOSC_EN;

    for (genvar i = 0; i < `PCM_NPINS; i++)
    begin : g_pin
        pcm_pin_mux u_mux
        (
            .dir_in(dir_bits[i]),
            .latch_bit(lat_bits[i]),
            .per_en(per_en[i]),
            .per_val(per_val[i]),
            .per_tri(per_tri[i]),
            .osc_own(osc_own[i]),
            .drive_val(drv_val[i]),
            .drive_en(drv_en[i])
        );
    end

    // Registered so every top output comes from a flop
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PIN_OUT <= 3'h0;
            PIN_OE <= 3'h0;
        end
        else
        begin
            PIN_OUT <= drv_val;
            PIN_OE <= drv_en;
        end
    end

    // ----------------------------------------
    // Peripheral inputs from the pins
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            CAPTURE_IN <= 1'b0;
            FIRST_TIMER_CNT <= 1'b0;
            SHARED_TIMER_CNT <= 1'b0;
            SLAVE_SEL_N <= 1'b1;
            TOSC_PINS_ACTIVE <= 1'b0;
            CONV_CH_READY <= 2'h0;
        end
        else
        begin
            CAPTURE_IN <= dir_bits[`PCM_L5] & dig_in[`PCM_L5];
            FIRST_TIMER_CNT <= dir_bits[`PCM_L5] & dig_in[`PCM_L5];
            SHARED_TIMER_CNT <= dir_bits[`PCM_L6] & dig_in[`PCM_L6];
            // Deselected while pin 6 drives out
            SLAVE_SEL_N <= !dir_bits[`PCM_L6] | dig_in[`PCM_L6];
            TOSC_PINS_ACTIVE <= TOSC_EN;
            CONV_CH_READY <= dir_bits[`PCM_L7:`PCM_L6];
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: PREADY rises on the second access cycle
    assign acc = PSEL && PENABLE;
    assign sel = pcm_decode(PADDR[7:0]);
    assign wr_hit = acc && pready_reg && PWRITE;
    assign levels = {dig_in, 5'h00};

    always_comb
    begin
        rd_next = `PCM_NO_BITS;
        unique case (sel)
            PCM_SEL_LEVELS: rd_next = levels;
            PCM_SEL_LATCH: rd_next = latch_reg;
            PCM_SEL_DIR: rd_next = dir_reg;
            PCM_SEL_ANS_LO: rd_next = ans_lo_reg;
            PCM_SEL_ANS_HI: rd_next = ans_hi_reg;
            PCM_SEL_NONE: rd_next = `PCM_NO_BITS;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pready_reg <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end
        else if (acc && !pready_reg)
        begin
            pready_reg <= 1'b1;
            PRDATA <= PWRITE ? 32'h0 : {24'h0, rd_next};
            PSLVERR <= (sel == PCM_SEL_NONE);
        end
        else
        begin
            pready_reg <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end
    assign PREADY = pready_reg;

    // ----------------------------------------
    // Software-written registers
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            latch_reg <= `PCM_LAT_RST;
        else if (wr_hit && (sel == PCM_SEL_LATCH || sel == PCM_SEL_LEVELS))
            latch_reg <= PWDATA[7:0];
    end
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            dir_reg <= `PCM_DIR_RST;
        else if (wr_hit && sel == PCM_SEL_DIR)
            dir_reg <= PWDATA[7:0];
    end
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ans_lo_reg <= `PCM_ANS_LO_RST;
        else if (wr_hit && sel == PCM_SEL_ANS_LO)
            ans_lo_reg <= PWDATA[7:0] & `PCM_ANS_LO_MASK;
    end
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ans_hi_reg <= `PCM_ANS_HI_RST;
        else if (wr_hit && sel == PCM_SEL_ANS_HI)
            ans_hi_reg <= PWDATA[7:0] & `PCM_ANS_HI_MASK;
    end

    // Buffer disables; ANALOG_SEL_HIGH bits 1:0 are pins 7 and 6 of this block, the rest pins outside it
    assign ANALOG_SEL_LOW =
        ans_lo_reg[`PCM_ANS_LO_TOP:`PCM_ANS_LO_BOT];
    assign ANALOG_SEL_HIGH = ans_hi_reg[`PCM_ANS_HI_TOP:0];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_acc_first;
        PSEL && PENABLE && !pready_reg;
    endsequence
    sequence s_lvl_read;
        s_acc_first ##0 !PWRITE ##0 (sel == PCM_SEL_LEVELS);
    endsequence
    sequence s_wr_lo;
        wr_hit ##0 (sel == PCM_SEL_ANS_LO);
    endsequence
    sequence s_wr_hi;
        wr_hit ##0 (sel == PCM_SEL_ANS_HI);
    endsequence
    property p_dir_in;
        dir_reg[`PCM_P5] |=> !PIN_OE[`PCM_L5];
    endproperty
    a_dir_in: assert property (p_dir_in)
        else $error("Input pin 5 still driven");
    property p_latch_drv;
        !dir_reg[`PCM_P5] && !CCP_OUT_EN && !PWM_A_EN
            |=> PIN_OE[`PCM_L5]
            && PIN_OUT[`PCM_L5] == $past(latch_reg[`PCM_P5]);
    endproperty
    a_latch_drv: assert property (p_latch_drv)
        else $error("Pin 5 not driving latch");
    property p_ccp_over;
        CCP_OUT_EN && !PWM_A_EN |=> PIN_OUT[`PCM_L5] == $past(CCP_OUT);
    endproperty
    a_ccp_over: assert property (p_ccp_over)
        else $error("Compare output lost on pin 5");
    property p_capture;
        dir_reg[`PCM_P5] |=> CAPTURE_IN == $past(pin_sync[`PCM_L5]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("Capture input wrong");
    property p_pwm_tri;
        PWM_A_EN && PWM_SHUTDOWN |=> !PIN_OE[`PCM_L5];
    endproperty
    a_pwm_tri: assert property (p_pwm_tri)
        else $error("Pin 5 driven during shutdown");
    property p_ss;
        dir_reg[`PCM_P6] && !ans_hi_reg[`PCM_ANS_C6] && !TOSC_EN
            |=> SLAVE_SEL_N == $past(pin_sync[`PCM_L6]);
    endproperty
    a_ss: assert property (p_ss)
        else $error("Slave select does not follow pin 6");
    property p_tcnt;
        !dir_reg[`PCM_P6] |=> !SHARED_TIMER_CNT && SLAVE_SEL_N;
    endproperty
    a_tcnt: assert property (p_tcnt)
        else $error("Output pin 6 feeds timer or select");
    property p_osc;
        TOSC_EN |=> PIN_OE[`PCM_L7:`PCM_L6] == 2'h0 && !SHARED_TIMER_CNT;
    endproperty
    a_osc: assert property (p_osc)
        else $error("Oscillator pins still digital");
    property p_spi;
        SPI_ACTIVE && !dir_reg[`PCM_P7] && !TOSC_EN
            |=> PIN_OE[`PCM_L7] && PIN_OUT[`PCM_L7] == $past(SPI_SDO);
    endproperty
    a_spi: assert property (p_spi)
        else $error("SPI data not on pin 7");
    property p_conv;
        dir_reg[`PCM_P7] && dir_reg[`PCM_P6] |=> CONV_CH_READY == 2'h3;
    endproperty
    a_conv: assert property (p_conv)
        else $error("Converter channels not ready");
    property p_dontcare;
        TOSC_EN && !dir_reg[`PCM_P7] |=> !PIN_OE[`PCM_L7];
    endproperty
    a_dontcare: assert property (p_dontcare)
        else $error("Direction bit not overridden");
    property p_ans_read;
        s_lvl_read ##0 ans_hi_reg[`PCM_ANS_C6]
            |=> PREADY && !PRDATA[`PCM_P6];
    endproperty
    a_ans_read: assert property (p_ans_read)
        else $error("Analog pin 6 read not zero");
    property p_ans_out;
        ans_hi_reg[`PCM_ANS_C7] && !dir_reg[`PCM_P7] && !SPI_ACTIVE
            && !TOSC_EN
            |=> PIN_OE[`PCM_L7]
            && PIN_OUT[`PCM_L7] == $past(latch_reg[`PCM_P7]);
    endproperty
    a_ans_out: assert property (p_ans_out)
        else $error("Analog select changed output drive");
    property p_lo_map;
        s_wr_lo |=> ANALOG_SEL_LOW == $past(PWDATA[7:3]);
    endproperty
    a_lo_map: assert property (p_lo_map)
        else $error("Low analog select not stored");
    property p_lo_unimpl;
        s_wr_lo |=> ans_lo_reg[2:0] == 3'h0;
    endproperty
    a_lo_unimpl: assert property (p_lo_unimpl)
        else $error("Low unimplemented bits set");
    property p_hi_map;
        s_wr_hi |=> ANALOG_SEL_HIGH == $past(PWDATA[3:0])
            && ans_hi_reg[7:4] == 4'h0;
    endproperty
    a_hi_map: assert property (p_hi_map)
        else $error("High analog select wrong");
    property p_rst;
        $rose(RESET_N) |-> ans_lo_reg == `PCM_ANS_LO_RST
            && ans_hi_reg == `PCM_ANS_HI_RST;
    endproperty
    a_rst: assert property (p_rst)
        else $error("Analog select not one after reset");
    property p_wait;
        s_acc_first |=> PREADY ##1 !PREADY;
    endproperty
    a_wait: assert property (p_wait)
        else $error("APB answer timing wrong");

endmodule : pcm_top
